// ### dioc_pkg.sv
// Shared constants and types for the digital I/O capture block
package dioc_pkg;
    localparam int WIDE_LINES   = 32;
    localparam int NARROW_LINES = 8;
    localparam int ALL_LINES    = 40;
    localparam int NARROW_BASE  = 32;
    localparam int DIV_WIDTH    = 16;
    localparam int CNT_WIDTH    = 32;
    localparam int FIFO_DEPTH   = 8;
    localparam int FIFO_AW      = 3;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET   = 16'h0002;
    localparam logic [DIV_WIDTH-1:0] DELAY_RESET = 16'h0002;
    localparam int CLK_MHZ      = 200;
    localparam int TIMEBASE_MHZ = 100;
    localparam int TB_RATIO     = CLK_MHZ / TIMEBASE_MHZ;
    // Line function codes
    localparam logic [1:0] FN_INPUT   = 2'h0;
    localparam logic [1:0] FN_OUTPUT  = 2'h1;
    localparam logic [1:0] FN_CAPTURE = 2'h2;
    // Strobe export select: none
    localparam logic [5:0] EXPORT_NONE = 6'h3f;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_RUN   = 5'b00100,
        ST_POST  = 5'b01000,
        ST_DONE  = 5'b10000
    } dioc_state_type;
endpackage

// ### dioc_fifo.sv
// Capture FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dioc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rdPtr;
        logic [AW-1:0]               wrPtr;
        logic [AW:0]                 count;
    } dioc_fifo_state_type;

    dioc_fifo_state_type st;
    dioc_fifo_state_type next_st;
    logic                doWrite;
    logic                doRead;

    always_comb
    begin
        next_st = st;
        doWrite = inValid && st.count != (AW+1)'(DEPTH);
        doRead  = outReady && st.count != '0;
        if (doWrite)
        begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (doRead)
            next_st.rdPtr = st.rdPtr + 1'b1;
        next_st.count = st.count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st.rdPtr <= '0;
            st.wrPtr <= '0;
            st.count <= '0;
            st.mem   <= '0;
        end
        else
            st <= next_st;
    end

    assign inReady  = st.count != (AW+1)'(DEPTH);
    assign outValid = st.count != '0;
    assign outData  = st.mem[st.rdPtr];
endmodule

// ### dioc_top.sv
// Digital I/O port with timed waveform capture engine
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R1 - Forty lines split into a 32-line wide and 8-line narrow port.
// R2 - Wide line y is function line y; narrow line y is 32+y.
// R3 - Every line individually output, static input, or capture (wide only).
// R4 - Static reads and writes happen only on single software commands.
// R5 - Both ports detect input changes, giving trigger and interrupt pulses.
// R6 - Waveform capture exists on the wide port only.
// R7 - Capture wide lines on chosen edge, rising or falling, of external strobe.
// R8 - Samples enter capture FIFO; a DMA engine drains it to memory.
// R9 - Strobe with FIFO full drops the sample and raises overflow.
// R10 - Strobe comes from internal divider unless external source selected.
// R11 - Strobe exported on any function line is driven inverted.
// R12 - Strobe edges are ignored when no acquisition runs.
// R13 - Active hold trigger makes strobe edges ignored until released.
// R14 - Begin trigger starts engine; finite end stops by hardware or software.
// R15 - Configurable delay from begin trigger to first strobe, default two.
// R16 - Finite mode takes preset sample count, then stops itself.
// R17 - Host uses finite mode whenever the end trigger is used.
// R18 - Continuous mode acquires until an explicit stop command.
// R19 - Engine accepts begin, end and hold trigger inputs.
// R20 - Single-point mode flags when software falls behind the strobe.
// R21 - Timebase defaults to onboard 100 MHz, divided to form the strobe.
// R22 - Retriggerable begin ignored during a burst, then re-arms.
// R23 - Hold trigger is level sensitive with programmable active level.
// R24 - End trigger ignored until pretrigger samples are captured.
// R25 - Overflow stays set until software clears it.
// R26 - Divider counts timebase ticks, pulses at the divisor, restarts.
module dioc_top #(
    parameter int DIV_W = dioc_pkg::DIV_WIDTH,
    parameter int CNT_W = dioc_pkg::CNT_WIDTH
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        reset,
    // Pins: 40 function lines, wide port is bits 31:0
    input  wire logic [39:0]                 pinIn,
    output logic [39:0]                      pinOut,
    output logic [39:0]                      pinOe,
    // Line configuration, two bits per line
    input  wire logic [79:0]                 lineFunction,
    input  wire logic [39:0]                 staticOutValue,
    input  wire logic                        staticWriteCmd,
    input  wire logic                        staticReadCmd,
    output logic [39:0]                      staticInValue,
    output logic                             staticReadDone,
    // Change detection
    input  wire logic [39:0]                 changeEnable,
    output logic                             changeTrigger,
    output logic                             changeInterrupt,
    output logic [39:0]                      changeLines,
    // Timing configuration
    input  wire logic [DIV_W-1:0]            strobeDivisor,
    input  wire logic [DIV_W-1:0]            startDelay,
    input  wire logic                        externalStrobeSel,
    input  wire logic                        externalTimebaseSel,
    input  wire logic                        strobeFallingEdge,
    input  wire logic [5:0]                  strobeExportLine,
    // Mode configuration
    input  wire logic                        finiteMode,
    input  wire logic                        singlePointMode,
    input  wire logic                        retriggerable,
    input  wire logic                        useEndTrigger,
    input  wire logic                        holdActiveLow,
    input  wire logic [CNT_W-1:0]            sampleCount,
    input  wire logic [CNT_W-1:0]            pretriggerCount,
    // Software commands and external sources (off-domain)
    input  wire logic                        softStart,
    input  wire logic                        softStop,
    input  wire logic                        overflowClear,
    input  wire logic                        lateClear,
    input  wire logic                        samplePointRead,
    input  wire logic                        extStrobe,
    input  wire logic                        extTimebase,
    input  wire logic                        beginTrigger,
    input  wire logic                        endTrigger,
    input  wire logic                        holdTrigger,
    // DMA drain side
    output logic                             dmaValid,
    input  wire logic                        dmaReady,
    output logic [31:0]                      dmaData,
    // Status
    output logic                             acquiring,
    output logic                             overflow,
    output logic                             lateFlag
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [39:0]               sync1;
        logic [39:0]               sync2;
        logic [39:0]               prevIn;
        logic [4:0]                ctlSync1;
        logic [4:0]                ctlSync2;
        logic [4:0]                ctlPrev;
        logic                      tbPhase;
        logic [DIV_W-1:0]          divCount;
        logic [DIV_W-1:0]          delayCount;
        logic [CNT_W-1:0]          taken;
        logic [CNT_W-1:0]          postLeft;
        dioc_pkg::dioc_state_type  fsm;
        logic                      strobeLevel;
        logic                      pendingPoint;
        logic [39:0]               pinOut;
        logic [39:0]               pinOe;
        logic [39:0]               staticIn;
        logic                      readDone;
        logic                      chgTrig;
        logic [39:0]               chgLines;
        logic                      acq;
        logic                      ovf;
        logic                      late;
        logic                      fifoValid;
        logic [31:0]               fifoData;
    } dioc_regs_type;

    dioc_regs_type st;
    dioc_regs_type next_st;

    logic        fifoReady;
    logic        fifoOutValid;
    logic [31:0] fifoOutData;

    // Control bits after two flops: strobe, timebase, begin, end, hold
    logic        extStrobeS;
    logic        extTbS;
    logic        beginS;
    logic        endS;
    logic        holdS;
    logic        tbTick;
    logic        intStrobe;
    logic        strobeEdge;
    logic        holding;
    logic        sampleNow;
    logic        beginEdge;
    logic        endEdge;
    logic        extEdge;
    logic [39:0] change;
    logic [39:0] isOut;
    logic [39:0] isCap;

    assign extStrobeS = st.ctlSync2[0];
    assign extTbS     = st.ctlSync2[1];
    assign beginS     = st.ctlSync2[2];
    assign endS       = st.ctlSync2[3];
    assign holdS      = st.ctlSync2[4];

    genvar g;
    generate
        for (g = 0; g < dioc_pkg::ALL_LINES; g++)
        begin : gLine
            assign isOut[g] = lineFunction[2*g +: 2] == dioc_pkg::FN_OUTPUT;
            // Narrow port lines never capture
            assign isCap[g] = (g < dioc_pkg::WIDE_LINES) &&
                lineFunction[2*g +: 2] == dioc_pkg::FN_CAPTURE; // R3 R6
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        // Two-flop synchronisers on every pin and outside control
        next_st.sync1    = pinIn;
        next_st.sync2    = st.sync1;
        next_st.ctlSync1 = {holdTrigger, endTrigger, beginTrigger,
                            extTimebase, extStrobe};
        next_st.ctlSync2 = st.ctlSync1;
        next_st.ctlPrev  = st.ctlSync2;

        // Timebase tick: 100 MHz from mclk, or external edge
        next_st.tbPhase = (st.tbPhase + 1'b1) == 1'(dioc_pkg::TB_RATIO)
                          ? 1'b0 : st.tbPhase + 1'b1;
        tbTick = externalTimebaseSel ? (extTbS && !st.ctlPrev[1])
                                     : (st.tbPhase == 1'b0); // R21

        // Divider, counting only while engine runs
        intStrobe = 1'b0;
        if (st.fsm == dioc_pkg::ST_IDLE || st.fsm == dioc_pkg::ST_DONE)
            next_st.divCount = '0;
        else if (tbTick && st.fsm != dioc_pkg::ST_DELAY)
        begin
            if (st.divCount + 1'b1 >= strobeDivisor)
            begin
                next_st.divCount = '0;
                intStrobe = 1'b1; // R26
            end
            else
                next_st.divCount = st.divCount + 1'b1; // R26
        end

        // Strobe source and active edge
        extEdge = strobeFallingEdge ? (!extStrobeS && st.ctlPrev[0])
                                    : (extStrobeS && !st.ctlPrev[0]); // R7
        strobeEdge = externalStrobeSel ? extEdge : intStrobe; // R10
        next_st.strobeLevel = externalStrobeSel ? extStrobeS
                            : (intStrobe ? 1'b1 : 1'b0);

        holding   = holdS ^ holdActiveLow; // R23
        beginEdge = (beginS && !st.ctlPrev[2]) || softStart; // R19
        endEdge   = endS && !st.ctlPrev[3]; // R19

        // Sample only while running and not held
        sampleNow = strobeEdge && !holding &&
                    (st.fsm == dioc_pkg::ST_RUN ||
                     st.fsm == dioc_pkg::ST_POST); // R12 R13

        next_st.fifoValid = 1'b0;
        if (sampleNow)
        begin
            if (fifoReady)
            begin
                next_st.fifoValid = 1'b1;
                next_st.fifoData  = st.sync2[31:0] & isCap[31:0]; // R7 R8
                next_st.taken     = st.taken + 1'b1;
            end
            else
                next_st.ovf = 1'b1; // R9
            if (singlePointMode)
            begin
                if (st.pendingPoint)
                    next_st.late = 1'b1; // R20
                next_st.pendingPoint = 1'b1;
            end
        end
        else if (samplePointRead)
            next_st.pendingPoint = 1'b0;
        if (overflowClear && !(sampleNow && !fifoReady))
            next_st.ovf = 1'b0; // R25
        if (lateClear && !(sampleNow && singlePointMode && st.pendingPoint))
            next_st.late = 1'b0;

        // Acquisition engine
        case (st.fsm)
            dioc_pkg::ST_IDLE:
            begin
                if (beginEdge)
                begin
                    next_st.fsm        = dioc_pkg::ST_DELAY; // R14
                    next_st.delayCount = '0;
                    next_st.taken      = '0;
                end
            end
            dioc_pkg::ST_DELAY:
            begin
                // Begin edges here and later are ignored
                if (tbTick)
                begin
                    if (st.delayCount + 1'b1 >= startDelay)
                        next_st.fsm = dioc_pkg::ST_RUN; // R15
                    else
                        next_st.delayCount = st.delayCount + 1'b1; // R15
                end
            end
            dioc_pkg::ST_RUN:
            begin
                if (useEndTrigger && endEdge &&
                    st.taken >= pretriggerCount) // R24
                begin
                    next_st.fsm      = dioc_pkg::ST_POST;
                    next_st.postLeft = sampleCount - pretriggerCount;
                end
                else if (finiteMode && !useEndTrigger &&
                         next_st.taken >= sampleCount)
                    next_st.fsm = dioc_pkg::ST_DONE; // R16
            end
            dioc_pkg::ST_POST:
            begin
                if (sampleNow && fifoReady)
                    next_st.postLeft = st.postLeft - 1'b1;
                if (st.postLeft == '0)
                    next_st.fsm = dioc_pkg::ST_DONE;
            end
            dioc_pkg::ST_DONE:
            begin
                // Burst over: re-arm when retriggerable
                if (retriggerable)
                    next_st.fsm = dioc_pkg::ST_IDLE; // R22
            end
            default:
                next_st.fsm = dioc_pkg::ST_IDLE;
        endcase
        // Software stop ends any mode, the only end for continuous
        if (softStop)
            next_st.fsm = dioc_pkg::ST_IDLE; // R14 R18
        next_st.acq = next_st.fsm != dioc_pkg::ST_IDLE &&
                      next_st.fsm != dioc_pkg::ST_DONE;

        // Static I/O on single commands only
        next_st.readDone = staticReadCmd;
        if (staticReadCmd)
            next_st.staticIn = st.sync2; // R4
        if (staticWriteCmd)
            next_st.pinOut = staticOutValue; // R4
        next_st.pinOe = isOut; // R1 R2 R3
        // Exported strobe overrides the line, inverted
        if (strobeExportLine < 6'(dioc_pkg::ALL_LINES))
        begin
            next_st.pinOut[strobeExportLine] = !next_st.strobeLevel; // R11
            next_st.pinOe[strobeExportLine]  = 1'b1;
        end

        // Change detection on input lines of both ports
        change = (st.sync2 ^ st.prevIn) & changeEnable & ~isOut; // R5
        next_st.prevIn   = st.sync2;
        next_st.chgTrig  = |change; // R5
        next_st.chgLines = change;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st          <= '0;
            st.fsm      <= dioc_pkg::ST_IDLE;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture FIFO toward the DMA engine
    dioc_fifo #(
        .WIDTH (32),
        .DEPTH (dioc_pkg::FIFO_DEPTH),
        .AW    (dioc_pkg::FIFO_AW)
    ) uFifo (
        .mclk     (mclk),
        .reset    (reset),
        .inValid  (st.fifoValid),
        .inReady  (fifoReady),
        .inData   (st.fifoData),
        .outValid (fifoOutValid),
        .outReady (dmaReady),
        .outData  (fifoOutData)
    ); // R8

    assign dmaValid        = fifoOutValid;
    assign dmaData         = fifoOutData;
    assign pinOut          = st.pinOut;
    assign pinOe           = st.pinOe;
    assign staticInValue   = st.staticIn;
    assign staticReadDone  = st.readDone;
    assign changeTrigger   = st.chgTrig;
    assign changeInterrupt = st.chgTrig;
    assign changeLines     = st.chgLines;
    assign acquiring       = st.acq;
    assign overflow        = st.ovf;
    assign lateFlag        = st.late;
endmodule

// ### dioc_asserts.sv
// Port-level assertions for the capture block
`timescale 1ns/1ps
module dioc_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // Observed ports
    input wire logic [39:0] pinOut,
    input wire logic [39:0] pinOe,
    input wire logic [79:0] lineFunction,
    input wire logic [5:0]  strobeExportLine,
    input wire logic [39:0] staticOutValue,
    input wire logic        staticWriteCmd,
    input wire logic        staticReadCmd,
    input wire logic        staticReadDone,
    input wire logic        finiteMode,
    input wire logic        softStart,
    input wire logic        overflowClear,
    input wire logic        dmaValid,
    input wire logic        dmaReady,
    input wire logic [31:0] dmaData,
    input wire logic        acquiring,
    input wire logic        overflow
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
////////////////////////////////////////////////////////////////////////////////
    a_read_answer:
        assert property (staticReadCmd |=> staticReadDone)
        else $error("static read not answered");
    a_write_lands:
        assert property (staticWriteCmd && strobeExportLine ==
            dioc_pkg::EXPORT_NONE |=> ((pinOut ^ $past(staticOutValue))
            & pinOe) == 40'h00_0000_0000)
        else $error("static write not on driven pins");
    a_input_released:
        assert property ((lineFunction[1:0] == dioc_pkg::FN_INPUT &&
            strobeExportLine == dioc_pkg::EXPORT_NONE)[*2] |-> !pinOe[0])
        else $error("input line driven");
    a_output_driven:
        assert property ((lineFunction[79:78] == dioc_pkg::FN_OUTPUT &&
            strobeExportLine == dioc_pkg::EXPORT_NONE)[*2] |-> pinOe[39])
        else $error("narrow output line not driven");
    a_idle_quiet:
        assert property ((!acquiring && !dmaValid)[*4] |=> !dmaValid)
        else $error("sample stored while idle");
    a_ovf_sticky:
        assert property (overflow && !overflowClear |=> overflow)
        else $error("overflow dropped without clear");
    a_ovf_clear:
        assert property ($fell(overflow) |-> $past(overflowClear))
        else $error("overflow fell without clear");
    a_dma_hold:
        assert property (dmaValid && !dmaReady |=>
            dmaValid && $stable(dmaData))
        else $error("stream word not held");
    a_start_run:
        assert property (softStart && !acquiring && !finiteMode |=> acquiring)
        else $error("start did not begin acquisition");
endmodule

// ### dioc_partner.sv
// Host memory drain model for the capture stream
`timescale 1ns/1ps
module dioc_partner (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Stream and host controls
    input  wire logic        dmaValid,
    output logic             dmaReady,
    input  wire logic [31:0] dmaData,
    input  wire logic        stall,
    output int               rxCount,
    output logic [31:0]      rxLast
);
    always_ff @(posedge mclk)
    begin
        dmaReady <= !stall && !reset;
        if (reset)
            rxCount <= 0;
        else if (dmaValid && dmaReady)
        begin
            rxCount <= rxCount + 1;
            rxLast  <= dmaData;
        end
    end
endmodule

// ### dioc_top_bench.sv
// Self-checking bench for the digital I/O capture block
`timescale 1ns/1ps
module dioc_top_bench;
    // Stimulus
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [6:0]  cmd = 7'h00;
    logic [39:0] pinIn = 40'h00_0000_0000;
    logic [79:0] lineFunction = {16'h0000, {32{dioc_pkg::FN_CAPTURE}}};
    logic [39:0] staticOutValue = 40'h00_0000_0000;
    logic [39:0] changeEnable = 40'h00_0000_0001;
    logic [5:0]  strobeExportLine = dioc_pkg::EXPORT_NONE;
    logic [15:0] strobeDivisor = 16'h0002;
    logic [15:0] startDelay = 16'h0002;
    logic [31:0] sampleCount = 32'h0000_0005;
    logic [31:0] pretriggerCount = 32'h0000_0003;
    logic        useEndTrigger = 1'b0, endTrigger = 1'b0;
    logic        externalStrobeSel = 1'b0, strobeFallingEdge = 1'b0;
    logic        finiteMode = 1'b0, singlePointMode = 1'b0;
    logic        retriggerable = 1'b0, holdActiveLow = 1'b0;
    logic        extStrobe = 1'b0, beginTrigger = 1'b0;
    logic        holdTrigger = 1'b0, stall = 1'b0;
    // Observation
    logic [39:0] pinOut, pinOe, staticInValue, changeLines;
    logic [31:0] dmaData, rxLast;
    logic        staticReadDone, changeTrigger, changeInterrupt, dmaValid;
    logic        dmaReady, acquiring, overflow, lateFlag;
    int          rxCount, r0, n, cycles = 0;
    int          num_errors = 0, total_checks = 0;

    dioc_top u_dut (
        .mclk, .reset, .pinIn, .pinOut, .pinOe, .lineFunction,
        .staticOutValue, .staticWriteCmd(cmd[5]), .staticReadCmd(cmd[6]),
        .staticInValue, .staticReadDone, .changeEnable, .changeTrigger,
        .changeInterrupt, .changeLines, .strobeDivisor, .startDelay,
        .externalStrobeSel, .externalTimebaseSel(1'b0), .strobeFallingEdge,
        .strobeExportLine, .finiteMode, .singlePointMode, .retriggerable,
        .useEndTrigger, .holdActiveLow, .sampleCount,
        .pretriggerCount, .softStart(cmd[0]),
        .softStop(cmd[1]), .overflowClear(cmd[2]), .lateClear(cmd[3]),
        .samplePointRead(cmd[4]), .extStrobe, .extTimebase(1'b0),
        .beginTrigger, .endTrigger, .holdTrigger, .dmaValid,
        .dmaReady, .dmaData, .acquiring, .overflow, .lateFlag
    );
    dioc_partner u_host (
        .mclk, .reset, .dmaValid, .dmaReady, .dmaData, .stall, .rxCount,
        .rxLast
    );

    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic pulse(input int b);
        cmd[b] <= 1'b1;
        @(posedge mclk);
        cmd <= 7'h00;
        @(posedge mclk);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_static;
        lineFunction[79:64] <= {8{dioc_pkg::FN_OUTPUT}};
        lineFunction[1:0] <= dioc_pkg::FN_INPUT;
        staticOutValue <= 40'ha5_0000_0000;
        pinIn <= 40'h00_0000_0001;
        pulse(5);
        for (n = 0; n < 8 && changeInterrupt !== 1'b1; n++) tick(1);
        chk({changeInterrupt, changeTrigger}, 40'h3);
        chk(changeLines, 40'h1);
        pulse(6);
        chk(staticReadDone, 40'h1);
        chk(pinOut[39:32], 40'ha5);
        chk(pinOe, 40'hff_0000_0000);
        chk(staticInValue[0], 40'h1);
        $display("static test done");
    endtask
    task automatic t_stream;
        lineFunction[79:64] <= 16'h0000;
        pinIn <= 40'h00_c3a5_0f1f;
        strobeExportLine <= 6'h23;
        r0 = rxCount;
        tick(4);
        pulse(0);
        for (n = 0; n < 300 && rxCount < r0 + 4; n++) tick(1);
        chk(pinOe[35], 40'h1);
        pulse(1);
        tick(12);
        chk(rxLast, 40'h00_c3a5_0f1e);
        r0 = rxCount;
        tick(40);
        chk(rxCount, r0);
        strobeExportLine <= dioc_pkg::EXPORT_NONE;
        $display("stream test done");
    endtask
    task automatic t_ext;
        externalStrobeSel <= 1'b1;
        strobeFallingEdge <= 1'b1;
        r0 = rxCount;
        pulse(0);
        tick(10);
        repeat (3)
        begin
            extStrobe <= 1'b1;
            tick(4);
            extStrobe <= 1'b0;
            tick(4);
        end
        tick(8);
        pulse(1);
        tick(8);
        chk(rxCount - r0, 40'h3);
        externalStrobeSel <= 1'b0;
        strobeFallingEdge <= 1'b0;
        $display("external strobe test done");
    endtask
    task automatic t_ovf;
        stall <= 1'b1;
        r0 = rxCount;
        pulse(0);
        for (n = 0; n < 300 && overflow !== 1'b1; n++) tick(1);
        pulse(1);
        tick(6);
        chk(overflow, 40'h1);
        pulse(2);
        chk(overflow, 40'h0);
        stall <= 1'b0;
        tick(20);
        chk(rxCount - r0, dioc_pkg::FIFO_DEPTH);
        $display("overflow test done");
    endtask
    task automatic t_hold;
        holdActiveLow <= 1'b1;
        r0 = rxCount;
        tick(4);
        pulse(0);
        tick(60);
        chk(rxCount - r0, 40'h0);
        holdTrigger <= 1'b1;
        for (n = 0; n < 200 && rxCount == r0; n++) tick(1);
        chk(rxCount > r0, 40'h1);
        pulse(1);
        holdTrigger <= 1'b0;
        holdActiveLow <= 1'b0;
        tick(12);
        $display("hold test done");
    endtask
    task automatic t_finite;
        finiteMode <= 1'b1;
        retriggerable <= 1'b1;
        r0 = rxCount;
        repeat (2)
        begin
            beginTrigger <= 1'b1;
            tick(4);
            beginTrigger <= 1'b0;
            tick(12);
            beginTrigger <= 1'b1;
            tick(4);
            beginTrigger <= 1'b0;
            tick(100);
        end
        chk(rxCount - r0, 40'ha);
        pulse(1);
        finiteMode <= 1'b0;
        retriggerable <= 1'b0;
        $display("finite test done");
    endtask
    task automatic t_ref;
        finiteMode <= 1'b1;
        useEndTrigger <= 1'b1;
        pulse(0);
        tick(6);
        endTrigger <= 1'b1;
        tick(4);
        endTrigger <= 1'b0;
        tick(30);
        chk(acquiring, 40'h1);
        endTrigger <= 1'b1;
        tick(40);
        chk(acquiring, 40'h0);
        pulse(1);
        endTrigger <= 1'b0;
        finiteMode <= 1'b0;
        useEndTrigger <= 1'b0;
        $display("reference test done");
    endtask
    task automatic t_late;
        singlePointMode <= 1'b1;
        pulse(0);
        pulse(4);
        for (n = 0; n < 200 && lateFlag !== 1'b1; n++) tick(1);
        pulse(1);
        chk(lateFlag, 40'h1);
        pulse(3);
        chk(lateFlag, 40'h0);
        singlePointMode <= 1'b0;
        tick(12);
        $display("late test done");
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(5);
        reset <= 1'b0;
        tick(1);
        t_static;
        t_stream;
        t_ext;
        t_ovf;
        t_hold;
        t_finite;
        t_ref;
        t_late;
        close_out;
    end
endmodule

bind dioc_top dioc_asserts u_chk (
    .mclk, .reset, .pinOut, .pinOe, .lineFunction, .strobeExportLine,
    .staticOutValue, .staticWriteCmd, .staticReadCmd, .staticReadDone,
    .finiteMode, .softStart, .overflowClear, .dmaValid, .dmaReady,
    .dmaData, .acquiring, .overflow
);
